/* rtl/rnp_pkg.sv */
// Summary of operation
// - Reset input held low long enough resets
// - Bidirectional mode drives reset pin low throughout sequence
// - Reset indication low on hardware, software, watchdog reset
// - Reset indication stays low until end-of-init
// - Falling edge on interrupt pin raises trap, except during the reset sequence
// - Power-down taken only if interrupt pin low
// - Power-down ignored while interrupt pin high
package rnp_pkg;
  // Least low time of the reset pin, in ns
  localparam int RST_MIN_NS      = 1000;
  // Clock period, in ns
  localparam int CLK_PERIOD_NS   = 20;
  // Low time in cycles, rounded up
  localparam int RST_MIN_CYC     = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Length of the internal reset sequence, in cycles
  localparam int RST_SEQ_CYC     = 64;
  // Counter width
  localparam int CNT_W           = 8;
  // Reset values of the indication and power-down outputs
  localparam logic RST_IND_RST   = 1'h0;
  localparam logic PD_RST        = 1'h0;
endpackage : rnp_pkg

/* rtl/rnp_ctrl.sv */
module rnp_ctrl #(
  parameter int MIN_LOW = rnp_pkg::RST_MIN_CYC, // Reset pin qualifying time, cycles
  parameter int SEQ_LEN = rnp_pkg::RST_SEQ_CYC  // Internal reset sequence, cycles
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Reset pin, open drain
  input  wire logic reset_input_pin_i,
  output logic      reset_input_pin_o,
  output logic      reset_input_pin_oe_o,
  // Reset indication output
  output logic      reset_indication_out_o,
  // Interrupt pin and trap request
  input  wire logic nmi_pin_i,
  output logic      nmi_trap_o,
  // Core side
  input  wire logic bidir_reset_enable_i,
  input  wire logic sw_reset_i,
  input  wire logic wdt_reset_i,
  input  wire logic end_of_init_instruction_i,
  input  wire logic powerdown_instruction_i,
  input  wire logic powerdown_cfg_bit_i,
  output logic      core_reset_o,
  output logic      powerdown_o
);
  // Counter width shared by both counters, declared before any use
  localparam int CNT_W = rnp_pkg::CNT_W;

  // Reset pin synchroniser
  logic             rst_s1_ff;    // First stage, read only by the second
  logic             rst_s2_ff;    // Settled pin level, low means asserted
  // Interrupt pin synchroniser and edge memory
  logic             nmi_s1_ff;    // First stage, read only by the second
  logic             nmi_s2_ff;    // Settled pin level
  logic             nmi_d_ff;     // Previous settled level for edge detection

  // Pin low-time counter
  logic [CNT_W-1:0] low_cnt_ff;   // Cycles the settled pin has been low
  logic [CNT_W-1:0] nxt_low_cnt;  // Next value, saturating
  // Internal reset sequence counter
  logic [CNT_W-1:0] seq_cnt_ff;   // Cycles spent in the sequence
  logic [CNT_W-1:0] nxt_seq_cnt;  // Next value, cleared on a new source

  // Output registers
  logic             core_rst_ff;  // Core held in reset
  logic             ind_ff;       // Reset indication level
  logic             drv_ff;       // Pulling the reset pin low ourselves
  logic             trap_ff;      // One-cycle trap request
  logic             pd_ff;        // Power-down entered

  // Sequence states
  typedef enum logic [0:0] {RNP_RUN, RNP_SEQ} rnp_state_t;
  rnp_state_t       state_ff;     // Current state
  rnp_state_t       nxt_state;    // Next state

  // Two flops before any detection; first stage only feeds the second.
  // No reset on these stages: they settle from the pins within two edges,
  // well inside the time the reset input is held.
  always_ff @(posedge clk_i) begin
    rst_s1_ff <= reset_input_pin_i;
    rst_s2_ff <= rst_s1_ff;
    nmi_s1_ff <= nmi_pin_i;
    nmi_s2_ff <= nmi_s1_ff;
  end

  // Decoding: pin qualified low, any reset source, edge
  wire pin_hit   = !rst_s2_ff && (low_cnt_ff == CNT_W'(MIN_LOW - 1));
  wire any_rst   = pin_hit || sw_reset_i || wdt_reset_i;
  wire nmi_fall  = nmi_d_ff && !nmi_s2_ff;
  wire pd_take   = powerdown_instruction_i && !powerdown_cfg_bit_i && !nmi_s2_ff;
  wire seq_done  = (state_ff == RNP_SEQ) && (seq_cnt_ff == CNT_W'(SEQ_LEN - 1));

  // Low time counter saturates, cleared by a high pin.
  // Also held clear while we pull the pin ourselves: our own pull-down
  // would otherwise requalify as a pin reset and lock the sequence forever.
  // Limitation: an outside hold during our own drive is not seen.
  assign nxt_low_cnt = (rst_s2_ff || drv_ff) ? '0 :
                       (low_cnt_ff == CNT_W'(MIN_LOW - 1)) ? low_cnt_ff : low_cnt_ff + 1'b1;
  // Sequence counter restarts on each new reset source
  assign nxt_seq_cnt = (any_rst || state_ff == RNP_RUN) ? '0 : seq_cnt_ff + 1'b1;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RNP_RUN: if (any_rst) nxt_state = RNP_SEQ;
      RNP_SEQ: if (seq_done && !any_rst) nxt_state = RNP_RUN;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff    <= RNP_SEQ;
      low_cnt_ff  <= '0;
      seq_cnt_ff  <= '0;
      nmi_d_ff    <= 1'h1;
      core_rst_ff <= 1'h1;
      ind_ff      <= rnp_pkg::RST_IND_RST;
      drv_ff      <= 1'h0;
      trap_ff     <= 1'h0;
      pd_ff       <= rnp_pkg::PD_RST;
    end else begin
      state_ff    <= nxt_state;
      low_cnt_ff  <= nxt_low_cnt;
      seq_cnt_ff  <= nxt_seq_cnt;
      nmi_d_ff    <= nmi_s2_ff;
      core_rst_ff <= (nxt_state == RNP_SEQ);
      // Low on any reset, high only after end of init
      if (any_rst) ind_ff <= 1'h0;
      else if (end_of_init_instruction_i && state_ff == RNP_RUN) ind_ff <= 1'h1;
      // Pull the pin for the whole sequence in bidirectional mode
      drv_ff      <= bidir_reset_enable_i && (nxt_state == RNP_SEQ);
      trap_ff     <= nmi_fall && state_ff == RNP_RUN;
      // Power-down held until a reset; wake-up is outside this block
      if (any_rst) pd_ff <= 1'h0;
      else if (pd_take && state_ff == RNP_RUN) pd_ff <= 1'h1;
    end
  end

  // Outputs straight from flops, except the pin data, which is tied low
  assign reset_input_pin_o      = 1'h0;
  assign reset_input_pin_oe_o   = drv_ff;
  assign reset_indication_out_o = ind_ff;
  assign nmi_trap_o             = trap_ff;
  assign core_reset_o           = core_rst_ff;
  assign powerdown_o            = pd_ff;

  // Assertions
  property p_ind_low_after_rst;
    @(posedge clk_i) disable iff (rst_i) (sw_reset_i || wdt_reset_i) |=> !reset_indication_out_o;
  endproperty
  a_ind_low_after_rst: assert property (p_ind_low_after_rst) else $error("indication not low after reset");
  property p_ind_needs_init;
    @(posedge clk_i) disable iff (rst_i) $rose(reset_indication_out_o) |-> $past(end_of_init_instruction_i);
  endproperty
  a_ind_needs_init: assert property (p_ind_needs_init) else $error("indication rose without init");
  property p_drive_in_seq;
    @(posedge clk_i) disable iff (rst_i) reset_input_pin_oe_o |-> core_reset_o && $past(bidir_reset_enable_i);
  endproperty
  a_drive_in_seq: assert property (p_drive_in_seq) else $error("pin driven outside sequence");
  property p_trap_edge;
    @(posedge clk_i) disable iff (rst_i) nmi_trap_o |-> $past(nmi_fall);
  endproperty
  a_trap_edge: assert property (p_trap_edge) else $error("trap without falling edge");
  property p_pd_nmi_low;
    @(posedge clk_i) disable iff (rst_i) $rose(powerdown_o) |-> !$past(nmi_s2_ff) && !$past(powerdown_cfg_bit_i);
  endproperty
  a_pd_nmi_low: assert property (p_pd_nmi_low) else $error("power-down with interrupt pin high");
  property p_pd_ignored;
    @(posedge clk_i) disable iff (rst_i) (!powerdown_o && nmi_s2_ff) |=> !powerdown_o;
  endproperty
  a_pd_ignored: assert property (p_pd_ignored) else $error("power-down taken while pin high");
  property p_pin_reset;
    @(posedge clk_i) disable iff (rst_i) pin_hit |=> core_reset_o;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset");
  property p_sync;
    @(posedge clk_i) disable iff (rst_i) $fell(nmi_pin_i) ##1 1 |-> ##1 !nmi_s2_ff || $past(nmi_pin_i);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser latency wrong");
  c_pin_reset: cover property (@(posedge clk_i) disable iff (rst_i) pin_hit);
  c_trap:      cover property (@(posedge clk_i) disable iff (rst_i) nmi_trap_o);
  c_pd:        cover property (@(posedge clk_i) disable iff (rst_i) $rose(powerdown_o));

  // Trap request lasts exactly one cycle
  property p_trap_pulse;
    @(posedge clk_i) disable iff (rst_i) nmi_trap_o |=> !nmi_trap_o;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap longer than one cycle");

  // No trap in the cycle after each sequence cycle
  property p_no_trap_in_seq;
    @(posedge clk_i) disable iff (rst_i) (state_ff == RNP_SEQ) |=> !nmi_trap_o;
  endproperty
  a_no_trap_in_seq: assert property (p_no_trap_in_seq) else $error("trap during reset sequence");

  // Bidirectional mode pulls the pin whenever the sequence is next
  property p_seq_drives;
    @(posedge clk_i) disable iff (rst_i) (nxt_state == RNP_SEQ && bidir_reset_enable_i) |=> reset_input_pin_oe_o;
  endproperty
  a_seq_drives: assert property (p_seq_drives) else $error("pin not pulled in sequence");

  // Indication stays low while the core is in reset
  property p_ind_low_in_seq;
    @(posedge clk_i) disable iff (rst_i) core_reset_o |-> !reset_indication_out_o;
  endproperty
  a_ind_low_in_seq: assert property (p_ind_low_in_seq) else $error("indication high during reset");

  // Any reset source cancels power-down
  property p_pd_cleared;
    @(posedge clk_i) disable iff (rst_i) any_rst |=> !powerdown_o;
  endproperty
  a_pd_cleared: assert property (p_pd_cleared) else $error("power-down kept over reset");

  // Sequence ends only from its last count
  property p_seq_end;
    @(posedge clk_i) disable iff (rst_i) $fell(core_reset_o) |-> $past(seq_done);
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("sequence cut short");

  // Low-time counter never passes its qualifying count
  property p_low_cnt_sat;
    @(posedge clk_i) disable iff (rst_i) low_cnt_ff <= CNT_W'(MIN_LOW - 1);
  endproperty
  a_low_cnt_sat: assert property (p_low_cnt_sat) else $error("low-time counter overran");

  // Second stage always follows the first by one edge
  property p_sync_lag;
    @(posedge clk_i) disable iff (rst_i) nmi_s2_ff == $past(nmi_s1_ff);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("synchroniser stage skipped");

  // Main scenarios: bidirectional drive and end of initialisation
  c_bidir:     cover property (@(posedge clk_i) disable iff (rst_i) reset_input_pin_oe_o);
  c_init:      cover property (@(posedge clk_i) disable iff (rst_i) $rose(reset_indication_out_o));
endmodule // rnp_ctrl

/* dv/rnp_partner.sv */
// Reset supervisor: open-drain line with pull-up
module rnp_partner (
  // Device pull-down and supervisor hold
  input  wire logic oe_i,
  input  wire logic hold_low_i,
  // Resolved line level
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released line floats up through the pull-up
  assign pin_o = ~(oe_i | hold_low_i);
endmodule // rnp_partner

/* dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, nmi = 1, bdr = 0, sw = 0, wdt = 0;
  logic eoi = 0, pd = 0, cfg = 0, hold = 0;
  // Slow oscillator unused, so software keeps it switched off
  logic slow_osc_off = 1;
  wire logic pin, oe, ind, trap, core, pdo;
  int err_count = 0, comparisons = 0, seed = 32'hcd98;
  rnp_partner u_rnp_partner (.oe_i(oe), .hold_low_i(hold), .pin_o(pin));
  // Short counts keep the run brief
  rnp_ctrl #(.MIN_LOW(4), .SEQ_LEN(8)) u_rnp_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .reset_input_pin_i(pin), .reset_input_pin_o(), .reset_input_pin_oe_o(oe),
    .reset_indication_out_o(ind), .nmi_pin_i(nmi), .nmi_trap_o(trap),
    .bidir_reset_enable_i(bdr), .sw_reset_i(sw), .wdt_reset_i(wdt),
    .end_of_init_instruction_i(eoi), .powerdown_instruction_i(pd),
    .powerdown_cfg_bit_i(cfg), .core_reset_o(core), .powerdown_o(pdo));
  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Compare one settled value
  task chk(input logic s, input logic e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %0h exp %0h", $time, s, e);
    end
  endtask
  // Inputs change at falling edges only
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Power-down request with given pin and config
  task pdn(input logic c, input logic n, input logic e);
    cfg = c;
    nmi = n;
    cyc(4);
    pd = 1;
    cyc(1);
    pd = 0;
    cyc(1);
    chk(pdo, e);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, well past the expected span
  initial begin
    #(3000 * 20);
    err_count++;
    finish_test;
  end
  initial begin
    cyc(4);
    rst_i = 0;
    cyc(6);
    chk(core, 1);
    cyc(4);
    chk(core, 0);
    chk(ind, 0);
    eoi = 1;
    cyc(1);
    eoi = 0;
    cyc(1);
    chk(ind, 1);
    $display("test init done");
    // Random gap of 1 to 4 cycles; the edge still lands at a falling edge
    cyc(1 + $unsigned($random(seed)) % 4);
    nmi = 0;
    cyc(3);
    chk(trap, 1);
    cyc(1);
    chk(trap, 0);
    $display("test trap done");
    pdn(1, 0, 0);
    pdn(0, 1, 0);
    pdn(0, 0, 1);
    $display("test powerdown done");
    sw = 1;
    cyc(1);
    sw = 0;
    chk(core, 1);
    chk(ind, 0);
    chk(pdo, 0);
    cyc(12);
    eoi = 1;
    cyc(1);
    eoi = 0;
    wdt = 1;
    cyc(1);
    wdt = 0;
    chk(ind, 0);
    $display("test soft resets done");
    // Supervisor holds the line past the qualifying time
    cyc(12);
    bdr = 1;
    hold = 1;
    cyc(8);
    hold = 0;
    cyc(2);
    chk(core, 1);
    chk(oe, 1);
    cyc(14);
    chk(oe, 0);
    chk(core, 0);
    $display("test pin reset done");
    finish_test;
  end
endmodule // tb
